// ===== common/tfc_params.svh
// constants, codes and timing figures for the tape format and interrupt control
// How it works
// - code 0006 selects 800 density
// - 0041 sets reverse read, 0040 clears it
// - format codes rejected while read/write busy
// - interrupt driven on switch-selected line
// - pending interrupt cleared by select, release, clear
// - only a connected unit may interrupt
// - 0020/0021 select ready-and-not-busy interrupt
// - end of operation interrupts 200 usec later
// - chained end interrupt waits for idle channel
// - abnormal conditions interrupt at check character
// - ready-to-not-ready interrupts at once, with exceptions
// - no new read/write while interrupt set
// - chained read interrupts at record end; the code has no such source, only the abnormal check-character one
// - chained write interrupts at record completion; the code has no such source, only the abnormal check-character one
// - read within 45 usec continues non-stop
// - write within 2.5 ms continues non-stop
// - write only with write enable and ready
// - non-stop write restarts after 4 ms, else 7
// - reverse read pairs frames, flags reverse assembly
// - reverse transfer to word count zero, gap ends
// - skip parity on leading check character
// - reverse read at load point hangs
// - undefined codes rejected; 0026/0027 clear interrupt
`ifndef TFC_PARAMS_SVH
`define TFC_PARAMS_SVH
// function codes (octal values written in hex)
`define TFC_FC_RELEASE 12'h000
`define TFC_FC_FMT_LAST 12'h005
`define TFC_FC_D556 12'h003
`define TFC_FC_D200 12'h004
`define TFC_FC_D800 12'h006
`define TFC_FC_MOT_FIRST 12'h008
`define TFC_FC_MOT_LAST 12'h00E
`define TFC_FC_IRQ_RNB_ON 12'h010
`define TFC_FC_IRQ_RNB_OFF 12'h011
`define TFC_FC_IRQ_EOP_ON 12'h012
`define TFC_FC_IRQ_EOP_OFF 12'h013
`define TFC_FC_IRQ_ABN_ON 12'h014
`define TFC_FC_IRQ_ABN_OFF 12'h015
`define TFC_FC_IRQ_CLR_A 12'h016
`define TFC_FC_IRQ_CLR_B 12'h017
`define TFC_FC_REV_CLR 12'h020
`define TFC_FC_REV_SET 12'h021
// status word bit positions
`define TFC_ST_READY 0
`define TFC_ST_BUSY 1
`define TFC_ST_WE 2
// frame layout: six data bits, parity on top
`define TFC_FR_PAR 6
// timing, in ns, and the clock period
`define TFC_CLK_NS 4
`define TFC_T_EOP_NS 200000
`define TFC_T_RDWIN_NS 45000
`define TFC_T_WRWIN_NS 2500000
`define TFC_T_NSWR_NS 4000000
`define TFC_T_NORMWR_NS 7000000
// counter width, large enough for the longest delay
`define TFC_CW 21
`endif

// ===== common/tfc_pkg.sv
// types shared by the tape format and interrupt control
`include "tfc_params.svh"
package tfc_pkg;
  typedef logic [`TFC_CW-1:0] tfc_cnt_t;
  // function code from the data channel
  typedef struct packed {
    logic valid;
    logic [11:0] code;
  } tfc_func_s;
  // state of the connected tape unit
  typedef struct packed {
    logic connected;
    logic connecting;
    logic ready;
    logic busy;
    logic load_point;
    logic write_enable;
  } tfc_unit_s;
  // tape events, one-cycle pulses except levels noted
  typedef struct packed {
    logic rcc;
    logic fm_found;
    logic lp_rewind;
    logic sbs_done;
    logic eot;
    logic file_mark;
    logic lost_data;
    logic vpe;
    logic lpe;
    logic gap;
  } tfc_evt_s;
  // one tape frame
  typedef struct packed {
    logic valid;
    logic rcc;
    logic [6:0] data;
  } tfc_frame_s;
  // one 12-bit byte to the channel
  typedef struct packed {
    logic valid;
    logic [11:0] data;
  } tfc_byte_s;
  typedef enum logic [2:0] {FC_FMT, FC_REV, FC_MOTION, FC_IRQSEL, FC_IRQCLR, FC_BAD} tfc_fc_e;
  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_RUN, ST_COAST, ST_HANG} tfc_state_e;
endpackage

// ===== hw/tfc_ctrl.sv
// function-code interpreter, interrupt and read/write sequencing of the tape control
//
// Design decisions made here: the plain strobed port.
`timescale 1ns/10ps
`include "tfc_params.svh"
module tfc_ctrl #(
  parameter int unsigned P_EOP_CYC = (`TFC_T_EOP_NS + `TFC_CLK_NS - 1) / `TFC_CLK_NS,
  parameter int unsigned P_RDWIN_CYC = `TFC_T_RDWIN_NS / `TFC_CLK_NS,
  parameter int unsigned P_WRWIN_CYC = `TFC_T_WRWIN_NS / `TFC_CLK_NS,
  parameter int unsigned P_NSWR_CYC = (`TFC_T_NSWR_NS + `TFC_CLK_NS - 1) / `TFC_CLK_NS,
  parameter int unsigned P_NORMWR_CYC = (`TFC_T_NORMWR_NS + `TFC_CLK_NS - 1) / `TFC_CLK_NS
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire tfc_pkg::tfc_func_s i_func,
  input wire logic [2:0] i_equip_sel,
  input wire tfc_pkg::tfc_unit_s i_unit,
  input wire tfc_pkg::tfc_evt_s i_evt,
  input wire logic i_chain_busy,
  input wire logic i_bcd_mode,
  input wire logic i_read_req,
  input wire logic i_write_req,
  input wire logic i_wc_zero,
  input wire tfc_pkg::tfc_frame_s i_frame,
  output logic o_reply,
  output logic o_reject,
  output logic [7:0] o_irq_lines,
  output logic o_density_800,
  output logic o_rev_read,
  output logic o_rev_assembly,
  output tfc_pkg::tfc_byte_s o_byte,
  output logic o_vpe,
  output logic o_eor,
  output logic o_motion_fwd,
  output logic o_motion_rev,
  output logic o_write_gate,
  output logic o_nonstop,
  output logic o_rw_refused,
  output logic o_busy,
  output logic [11:0] o_status
);
  import tfc_pkg::*;

  // sort a function code into its class
  function automatic tfc_fc_e fc_class(input logic [11:0] c);
    if (c <= `TFC_FC_D800) begin
      fc_class = FC_FMT;
    end else if (c >= `TFC_FC_MOT_FIRST && c <= `TFC_FC_MOT_LAST) begin
      fc_class = FC_MOTION;
    end else if (c >= `TFC_FC_IRQ_RNB_ON && c <= `TFC_FC_IRQ_ABN_OFF) begin
      fc_class = FC_IRQSEL;
    end else if (c == `TFC_FC_IRQ_CLR_A || c == `TFC_FC_IRQ_CLR_B) begin
      fc_class = FC_IRQCLR;
    end else if (c == `TFC_FC_REV_SET || c == `TFC_FC_REV_CLR) begin
      fc_class = FC_REV;
    end else begin
      fc_class = FC_BAD;
    end
  endfunction

  // vertical parity: odd ones in binary, even in coded mode
  function automatic logic par_ok(input logic [6:0] f, input logic bcd);
    par_ok = (^f) ^ bcd;
  endfunction

  tfc_state_e state_q; // read/write sequencer
  logic busy; // read/write control busy
  tfc_fc_e fcls; // class of the incoming code
  logic fc_take; // code accepted and executed
  logic sel_rnb_q, sel_eop_q, sel_abn_q; // interrupt selections
  logic irq_q; // irq_pending_flop
  logic irq_set, irq_clr; // interrupt set and clear terms
  logic rel_exec_q; // release code executing
  logic ready_q; // last ready level
  logic eop_wait_q; // end-of-operation delay running
  tfc_cnt_t eop_cnt_q; // end-of-operation delay count
  logic eop_fire_q; // delay over, waiting for channel idle
  logic abn_q; // abnormal condition seen this record
  logic op_wr_q; // current operation is a write
  tfc_cnt_t win_cnt_q; // non-stop window count
  tfc_cnt_t dly_cnt_q; // write start delay count
  logic rev_q; // reverse read selected
  logic xfer_q; // reverse transfer still wanted
  logic half_q; // first frame of a pair held
  logic [5:0] half_d_q; // held frame data
  logic first_q; // next frame is the first of the record
  logic rec_end; // record end for the current op
  logic start_ok; // read/write may begin now

  assign busy = (state_q != ST_IDLE);
  assign fcls = fc_class(i_func.code);
  // format, reverse and motion codes need an idle control; other defined codes always run
  assign fc_take = i_func.valid && (fcls != FC_BAD) &&
                   !(busy && (fcls == FC_FMT || fcls == FC_REV || fcls == FC_MOTION));
  assign rec_end = op_wr_q ? i_evt.rcc : i_evt.gap;
  assign start_ok = !irq_q && (state_q == ST_IDLE || state_q == ST_COAST);

  // reply or reject, one cycle after the code
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_reply <= 1'b0;
      o_reject <= 1'b0;
    end else begin
      o_reply <= fc_take;
      o_reject <= i_func.valid && !fc_take;
    end
  end

  // density and reverse-read format flags
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_density_800 <= 1'b0;
      rev_q <= 1'b0;
      o_rev_read <= 1'b0;
    end else if (fc_take) begin
      // other density codes leave 800
      if (i_func.code inside {`TFC_FC_D556, `TFC_FC_D200, `TFC_FC_D800}) begin
        o_density_800 <= (i_func.code == `TFC_FC_D800);
      end
      if (i_func.code == `TFC_FC_REV_SET) begin
        rev_q <= 1'b1;
        o_rev_read <= 1'b1;
      end else if (i_func.code == `TFC_FC_REV_CLR) begin
        rev_q <= 1'b0;
        o_rev_read <= 1'b0;
      end
    end
  end

  // interrupt selections, set and released by their codes
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sel_rnb_q <= 1'b0;
      sel_eop_q <= 1'b0;
      sel_abn_q <= 1'b0;
    end else if (fc_take && fcls == FC_IRQSEL) begin
      unique case (i_func.code)
        `TFC_FC_IRQ_RNB_ON: sel_rnb_q <= 1'b1;
        `TFC_FC_IRQ_RNB_OFF: sel_rnb_q <= 1'b0;
        `TFC_FC_IRQ_EOP_ON: sel_eop_q <= 1'b1;
        `TFC_FC_IRQ_EOP_OFF: sel_eop_q <= 1'b0;
        `TFC_FC_IRQ_ABN_ON: sel_abn_q <= 1'b1;
        default: sel_abn_q <= 1'b0;
      endcase
    end
  end

  // release-code window and last ready level
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rel_exec_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      rel_exec_q <= fc_take && (i_func.code == `TFC_FC_RELEASE);
      ready_q <= i_unit.ready;
    end
  end

  // end-of-operation delay, then hold until the channel is idle
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      eop_wait_q <= 1'b0;
      eop_cnt_q <= '0;
      eop_fire_q <= 1'b0;
    end else if (!sel_eop_q) begin
      eop_wait_q <= 1'b0;
      eop_fire_q <= 1'b0;
    end else if (i_unit.connected && (i_evt.rcc || i_evt.fm_found ||
                 i_evt.lp_rewind || i_evt.sbs_done)) begin
      eop_wait_q <= 1'b1;
      eop_cnt_q <= `TFC_CW'(P_EOP_CYC - 1);
    end else if (eop_wait_q) begin
      if (eop_cnt_q == '0) begin
        eop_wait_q <= 1'b0;
        eop_fire_q <= 1'b1;
      end else begin
        eop_cnt_q <= eop_cnt_q - 1'b1;
      end
    end else if (eop_fire_q && !i_chain_busy && i_unit.connected) begin
      eop_fire_q <= 1'b0;
    end
  end

  // abnormal conditions gathered until the check character
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      abn_q <= 1'b0;
    end else if (i_evt.rcc || !i_unit.connected) begin
      abn_q <= 1'b0;
    end else if (i_evt.eot || i_evt.file_mark || i_unit.load_point ||
                 i_evt.vpe || i_evt.lpe || i_evt.lost_data || o_vpe) begin
      abn_q <= 1'b1;
    end
  end

  // sources that raise the interrupt
  always_comb begin
    irq_set = 1'b0;
    if (i_unit.connected) begin
      if (sel_rnb_q && i_unit.ready && !i_unit.busy) begin
        irq_set = 1'b1;
      end
      if (eop_fire_q && !eop_wait_q && !i_chain_busy) begin
        irq_set = 1'b1;
      end
      // abnormal conditions raise it at the check character
      if (sel_abn_q && i_evt.rcc && (abn_q || i_evt.eot || i_evt.lost_data ||
          i_evt.vpe || i_evt.lpe || i_evt.file_mark || i_unit.load_point)) begin
        irq_set = 1'b1;
      end
      if (sel_abn_q && ready_q && !i_unit.ready && !i_unit.connecting &&
          !rel_exec_q) begin
        irq_set = 1'b1;
      end
    end
  end

  // any select code, release of all three, or 0026/0027 clears it
  assign irq_clr = fc_take && (fcls == FC_IRQSEL || fcls == FC_IRQCLR);

  // irq_pending_flop: a new set beats a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      irq_q <= 1'b0;
    end else if (irq_set) begin
      irq_q <= 1'b1;
    end else if (irq_clr || !(sel_rnb_q || sel_eop_q || sel_abn_q)) begin
      irq_q <= 1'b0;
    end
  end

  // interrupt onto the line named by the switch
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_irq_lines <= 8'h00;
    end else begin
      o_irq_lines <= {7'h00, irq_q} << i_equip_sel;
    end
  end

  // read/write sequencer
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
      op_wr_q <= 1'b0;
      o_nonstop <= 1'b0;
      win_cnt_q <= '0;
      dly_cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_COAST: begin
          if (start_ok && i_write_req) begin
            op_wr_q <= 1'b1;
            o_nonstop <= (state_q == ST_COAST);
            if (!(i_unit.write_enable && i_unit.ready)) begin
              state_q <= ST_HANG;
            end else begin
              state_q <= ST_DELAY;
              dly_cnt_q <= (state_q == ST_COAST) ? `TFC_CW'(P_NSWR_CYC - 1) :
                           `TFC_CW'(P_NORMWR_CYC - 1);
            end
          end else if (start_ok && i_read_req) begin
            op_wr_q <= 1'b0;
            o_nonstop <= (state_q == ST_COAST);
            // reverse from load point never moves
            state_q <= (rev_q && i_unit.load_point) ? ST_HANG : ST_RUN;
          end else if (state_q == ST_COAST) begin
            if (win_cnt_q == '0) begin
              state_q <= ST_IDLE;
            end else begin
              win_cnt_q <= win_cnt_q - 1'b1;
            end
          end
        end
        ST_DELAY: begin
          if (dly_cnt_q == '0) begin
            state_q <= ST_RUN;
          end else begin
            dly_cnt_q <= dly_cnt_q - 1'b1;
          end
        end
        ST_RUN: begin
          // interrupt or unchained record end opens the non-stop window
          if (irq_q || (rec_end && !i_chain_busy)) begin
            state_q <= ST_COAST;
            win_cnt_q <= op_wr_q ? `TFC_CW'(P_WRWIN_CYC - 1) :
                         `TFC_CW'(P_RDWIN_CYC - 1);
          end
        end
        ST_HANG: begin
          state_q <= ST_HANG;
        end
      endcase
    end
  end

  // motion, write gate, busy and refusal, one cycle behind the state
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_motion_fwd <= 1'b0;
      o_motion_rev <= 1'b0;
      o_write_gate <= 1'b0;
      o_busy <= 1'b0;
      o_rw_refused <= 1'b0;
    end else begin
      o_motion_fwd <= (state_q inside {ST_DELAY, ST_RUN, ST_COAST}) && !(rev_q && !op_wr_q);
      o_motion_rev <= (state_q inside {ST_RUN, ST_COAST}) && rev_q && !op_wr_q;
      o_write_gate <= (state_q == ST_RUN) && op_wr_q && i_unit.write_enable &&
                      i_unit.ready;
      o_busy <= busy;
      o_rw_refused <= (i_read_req || i_write_req) && irq_q;
    end
  end

  // status word: ready, busy, write enable
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_status <= 12'h000;
    end else begin
      o_status <= 12'h000;
      o_status[`TFC_ST_READY] <= i_unit.ready;
      o_status[`TFC_ST_BUSY] <= busy;
      o_status[`TFC_ST_WE] <= i_unit.write_enable;
    end
  end

  // reverse transfer runs from the read start to word count zero
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      xfer_q <= 1'b0;
    end else if (start_ok && i_read_req && !i_write_req && rev_q && !i_unit.load_point) begin
      xfer_q <= 1'b1;
    end else if (i_wc_zero || state_q == ST_IDLE) begin
      xfer_q <= 1'b0;
    end
  end

  // frame pairing and parity for reverse read
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      half_q <= 1'b0;
      half_d_q <= 6'h00;
      first_q <= 1'b1;
      o_byte <= '0;
      o_vpe <= 1'b0;
    end else begin
      o_byte.valid <= 1'b0;
      o_vpe <= 1'b0;
      if (state_q != ST_RUN || i_evt.gap) begin
        half_q <= 1'b0;
        first_q <= 1'b1;
      end else if (i_frame.valid && rev_q && !op_wr_q) begin
        first_q <= 1'b0;
        // a leading check character goes unchecked
        o_vpe <= !par_ok(i_frame.data, i_bcd_mode) && !(first_q && i_frame.rcc);
        if (!(first_q && i_frame.rcc) && xfer_q) begin
          if (half_q) begin
            // frames arrive low half first when running backward
            o_byte.valid <= 1'b1;
            o_byte.data <= {i_frame.data[5:0], half_d_q};
          end else begin
            half_d_q <= i_frame.data[5:0];
          end
          half_q <= !half_q;
        end
      end
    end
  end

  // reverse assembly flag and end of record
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rev_assembly <= 1'b0;
      o_eor <= 1'b0;
    end else begin
      o_rev_assembly <= xfer_q;
      o_eor <= (state_q == ST_RUN) && !op_wr_q && i_evt.gap;
    end
  end
endmodule

// ===== verification/tfc_chan_model.sv
// data channel model: function codes, read and write signals, chaining
`timescale 1ns/10ps
module tfc_chan_model (
  input wire logic i_clk,
  input wire logic i_reply,
  input wire logic i_reject,
  output tfc_pkg::tfc_func_s o_func,
  output logic o_read_req,
  output logic o_write_req,
  output logic o_wc_zero,
  output logic o_chain_busy
);
  import tfc_pkg::*;
  // idle channel from time zero
  initial begin
    o_func = '0;
    o_read_req = 1'b0;
    o_write_req = 1'b0;
    o_wc_zero = 1'b0;
    o_chain_busy = 1'b0;
  end
  // one code for one cycle, answer taken in the cycle after
  task automatic code(input logic [11:0] c, output logic [1:0] ans);
    @(posedge i_clk);
    o_func <= '{valid: 1'b1, code: c};
    @(posedge i_clk);
    o_func.valid <= 1'b0;
    @(posedge i_clk);
    ans = {i_reply, i_reject};
  endtask
  // one-cycle pulse: 0 read, 1 write, 2 word count zero
  // the channel issues one request and returns without waiting on the block
  task automatic pulse(input int k);
    @(posedge i_clk);
    {o_read_req, o_write_req, o_wc_zero} <= 3'b100 >> k;
    @(posedge i_clk);
    {o_read_req, o_write_req, o_wc_zero} <= 3'b000;
  endtask
  // chaining level
  task automatic chain(input logic b);
    @(posedge i_clk);
    o_chain_busy <= b;
  endtask
endmodule

// ===== verification/tfc_ctrl_chk.sv
// port assertions for the tape format and interrupt control
`timescale 1ns/10ps
`include "tfc_params.svh"
module tfc_ctrl_chk (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire tfc_pkg::tfc_func_s i_func,
  input wire logic [2:0] i_equip_sel,
  input wire tfc_pkg::tfc_unit_s i_unit,
  input wire tfc_pkg::tfc_evt_s i_evt,
  input wire logic i_read_req,
  input wire logic i_write_req,
  input wire logic o_reply,
  input wire logic o_reject,
  input wire logic [7:0] o_irq_lines,
  input wire logic o_density_800,
  input wire logic o_rev_read,
  input wire logic o_motion_rev,
  input wire logic o_eor,
  input wire logic o_write_gate,
  input wire logic o_rw_refused,
  input wire logic [11:0] o_status
);
  import tfc_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // code offered, then replied
  sequence s_ok(logic [11:0] c);
    i_func.valid && i_func.code == c ##1 o_reply;
  endsequence
  property p_answer;
    i_func.valid |=> o_reply ^ o_reject;
  endproperty
  property p_d800;
    s_ok(12'h006) |-> o_density_800;
  endproperty
  property p_rev_set;
    s_ok(12'h021) |-> o_rev_read;
  endproperty
  property p_rev_clr;
    s_ok(12'h020) |-> !o_rev_read;
  endproperty
  property p_undef;
    i_func.valid && i_func.code == 12'h007 |=> o_reject && !o_reply;
  endproperty
  property p_line;
    o_irq_lines == 8'h00 || o_irq_lines == (8'h01 << $past(i_equip_sel));
  endproperty
  property p_refuse;
    (i_read_req || i_write_req) && o_irq_lines != 8'h00 && !i_func.valid
      && !$past(i_func.valid) |=> o_rw_refused;
  endproperty
  property p_gate;
    o_write_gate |-> $past(i_unit.write_enable) && $past(i_unit.ready);
  endproperty
  property p_status;
    $past(i_reset_n) |-> o_status[`TFC_ST_WE] == $past(i_unit.write_enable)
      && o_status[`TFC_ST_READY] == $past(i_unit.ready);
  endproperty
  property p_eor;
    i_evt.gap && o_motion_rev |=> o_eor;
  endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  a_d800: assert property (p_d800) else $error("density not set");
  a_rev_set: assert property (p_rev_set) else $error("reverse not set");
  a_rev_clr: assert property (p_rev_clr) else $error("reverse not cleared");
  a_undef: assert property (p_undef) else $error("undefined code taken");
  a_line: assert property (p_line) else $error("wrong interrupt line");
  a_refuse: assert property (p_refuse) else $error("request not refused");
  a_gate: assert property (p_gate) else $error("write without enable");
  a_status: assert property (p_status) else $error("status bits wrong");
  a_eor: assert property (p_eor) else $error("no record end");
endmodule
bind tfc_ctrl tfc_ctrl_chk i_tfc_ctrl_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_func(i_func), .i_equip_sel(i_equip_sel), .i_unit(i_unit), .i_evt(i_evt),
  .i_read_req(i_read_req), .i_write_req(i_write_req), .o_reply(o_reply),
  .o_reject(o_reject), .o_irq_lines(o_irq_lines), .o_density_800(o_density_800),
  .o_rev_read(o_rev_read), .o_motion_rev(o_motion_rev), .o_eor(o_eor),
  .o_write_gate(o_write_gate), .o_rw_refused(o_rw_refused), .o_status(o_status));

// ===== verification/tfc_ctrl_test.sv
// self-checking bench for the tape format and interrupt control
`timescale 1ns/10ps
module tfc_ctrl_test;
  import tfc_pkg::*;
  logic i_clk; // 250 MHz
  logic i_reset_n; // sync, active low
  tfc_func_s func; // from channel model
  tfc_unit_s unit; // tape unit levels
  tfc_evt_s evt; // tape event pulses
  tfc_frame_s frame; // tape frames
  tfc_byte_s byte_o; // bytes to channel
  logic rd, wr, wcz, chain, reply, reject, rasm, vpe, eor, fwd, rev, gate;
  logic nonstop, refused, busy, d800, rev_rd, bcd = 1'b0;
  logic [2:0] esel = 3'h5; // equipment switch
  logic [7:0] lines; // interrupt lines
  logic [11:0] status;
  logic [11:0] last_byte; // last byte seen
  logic [1:0] ans; // {reply, reject}
  int n_errors, comparisons, n_vpe, n_eor;
  // defined codes, then undefined ones
  localparam logic [11:0] DEFS [24] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004,
    12'h005, 12'h006, 12'h008, 12'h009, 12'h00A, 12'h00B, 12'h00C, 12'h00D, 12'h00E,
    12'h010, 12'h011, 12'h012, 12'h013, 12'h014, 12'h015, 12'h016, 12'h017, 12'h020,
    12'h021};
  localparam logic [11:0] BADS [5] = '{12'h007, 12'h00F, 12'h018, 12'h022, 12'h1FF};
  tfc_ctrl #(.P_EOP_CYC(20), .P_RDWIN_CYC(10), .P_WRWIN_CYC(30), .P_NSWR_CYC(40),
    .P_NORMWR_CYC(70)) i_tfc_ctrl (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_func(func), .i_equip_sel(esel), .i_unit(unit), .i_evt(evt),
    .i_chain_busy(chain), .i_bcd_mode(bcd), .i_read_req(rd), .i_write_req(wr),
    .i_wc_zero(wcz), .i_frame(frame), .o_reply(reply), .o_reject(reject),
    .o_irq_lines(lines), .o_density_800(d800), .o_rev_read(rev_rd),
    .o_rev_assembly(rasm), .o_byte(byte_o), .o_vpe(vpe), .o_eor(eor),
    .o_motion_fwd(fwd), .o_motion_rev(rev), .o_write_gate(gate), .o_nonstop(nonstop),
    .o_rw_refused(refused), .o_busy(busy), .o_status(status));
  tfc_chan_model i_tfc_chan_model (.i_clk(i_clk), .i_reply(reply), .i_reject(reject),
    .o_func(func), .o_read_req(rd), .o_write_req(wr), .o_wc_zero(wcz),
    .o_chain_busy(chain));
  // clock
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // capture pulsed outputs
  always @(posedge i_clk) begin
    if (byte_o.valid === 1'b1) last_byte <= byte_o.data;
    if (vpe === 1'b1) n_vpe++;
    if (eor === 1'b1) n_eor++;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic rst();
    i_reset_n <= 1'b0;
    cyc(4);
    i_reset_n <= 1'b1;
    cyc(1);
  endtask
  // value compare
  task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // code and its answer
  task automatic fc(input logic [11:0] c, input logic [1:0] e);
    i_tfc_chan_model.code(c, ans);
    chk("answer", 12'(e), 12'(ans));
  endtask
  task automatic ev(input tfc_evt_s e);
    @(posedge i_clk);
    evt <= e;
    @(posedge i_clk);
    evt <= '0;
  endtask
  task automatic fr(input logic [6:0] d, input logic r);
    @(posedge i_clk);
    frame <= '{valid: 1'b1, rcc: r, data: d};
    @(posedge i_clk);
    frame.valid <= 1'b0;
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
  initial begin
    unit = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    evt = '0;
    frame = '0;
    rst();
    chk("lines", 12'h000, 12'(lines));
    foreach (DEFS[k]) begin
      fc(DEFS[k], 2'b10);
      if (DEFS[k] == 12'h006) chk("d800", 12'h001, 12'(d800));
    end
    foreach (BADS[k]) fc(BADS[k], 2'b01);
    chk("rev", 12'h001, 12'(rev_rd));
    fc(12'h020, 2'b10);
    chk("rev", 12'h000, 12'(rev_rd));
    // abnormal end, refusal, clears
    fc(12'h014, 2'b10);
    ev('{eot: 1'b1, default: 1'b0});
    ev('{rcc: 1'b1, default: 1'b0});
    cyc(3);
    chk("lines", 12'h020, 12'(lines));
    i_tfc_chan_model.pulse(0);
    cyc(1);
    chk("refused", 12'h001, 12'(refused));
    fc(12'h016, 2'b10);
    cyc(2);
    chk("lines", 12'h000, 12'(lines));
    unit.ready <= 1'b0;
    cyc(4);
    chk("lines", 12'h020, 12'(lines));
    unit.ready <= 1'b1;
    fc(12'h015, 2'b10);
    cyc(2);
    chk("lines", 12'h000, 12'(lines));
    fc(12'h014, 2'b10);
    unit.connected <= 1'b0;
    ev('{file_mark: 1'b1, lpe: 1'b1, default: 1'b0});
    ev('{rcc: 1'b1, vpe: 1'b1, lost_data: 1'b1, default: 1'b0});
    cyc(4);
    chk("lines", 12'h000, 12'(lines));
    unit <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    cyc(4);
    chk("lines", 12'h000, 12'(lines));
    unit <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    fc(12'h015, 2'b10);
    // end of operation, delay and chaining
    fc(12'h012, 2'b10);
    ev('{lp_rewind: 1'b1, default: 1'b0});
    cyc(18);
    chk("lines", 12'h000, 12'(lines));
    cyc(10);
    chk("lines", 12'h020, 12'(lines));
    fc(12'h012, 2'b10);
    i_tfc_chan_model.chain(1'b1);
    ev('{fm_found: 1'b1, default: 1'b0});
    cyc(40);
    chk("lines", 12'h000, 12'(lines));
    i_tfc_chan_model.chain(1'b0);
    cyc(4);
    chk("lines", 12'h020, 12'(lines));
    fc(12'h013, 2'b10);
    // ready and not busy, on another switch line
    esel <= 3'h2;
    fc(12'h010, 2'b10);
    cyc(3);
    chk("lines", 12'h004, 12'(lines));
    fc(12'h011, 2'b10);
    cyc(2);
    chk("lines", 12'h000, 12'(lines));
    // forward read: busy refusals, read window
    i_tfc_chan_model.pulse(0);
    cyc(2);
    chk("fwd", 12'h001, 12'(fwd));
    fc(12'h006, 2'b01);
    fc(12'h021, 2'b01);
    ev('{gap: 1'b1, default: 1'b0});
    cyc(3);
    i_tfc_chan_model.pulse(0);
    cyc(3);
    chk("nonstop", 12'h001, 12'(nonstop));
    ev('{gap: 1'b1, default: 1'b0});
    cyc(20);
    chk("fwd", 12'h000, 12'(fwd));
    i_tfc_chan_model.pulse(0);
    cyc(3);
    chk("nonstop", 12'h000, 12'(nonstop));
    ev('{gap: 1'b1, default: 1'b0});
    cyc(20);
    // write: normal start, then non-stop start
    i_tfc_chan_model.pulse(1);
    cyc(60);
    chk("gate", 12'h000, 12'(gate));
    cyc(20);
    chk("gate", 12'h001, 12'(gate));
    ev('{rcc: 1'b1, default: 1'b0});
    cyc(5);
    i_tfc_chan_model.pulse(1);
    cyc(30);
    chk("nonstop", 12'h001, 12'(nonstop));
    chk("gate", 12'h000, 12'(gate));
    cyc(15);
    chk("gate", 12'h001, 12'(gate));
    ev('{rcc: 1'b1, default: 1'b0});
    cyc(40);
    chk("fwd", 12'h000, 12'(fwd));
    // reverse read: pairing, parity, record end
    fc(12'h021, 2'b10);
    i_tfc_chan_model.pulse(0);
    cyc(3);
    chk("rev", 12'h001, 12'(rev));
    chk("rasm", 12'h001, 12'(rasm));
    fr(7'h00, 1'b1);
    fr(7'h01, 1'b0);
    fr(7'h43, 1'b0);
    cyc(2);
    chk("byte", 12'h0C1, last_byte);
    chk("vpe", 12'h000, 12'(n_vpe));
    fr(7'h03, 1'b0);
    cyc(2);
    chk("vpe", 12'h001, 12'(n_vpe));
    bcd <= 1'b1;
    fr(7'h03, 1'b0);
    cyc(2);
    chk("vpe", 12'h001, 12'(n_vpe));
    i_tfc_chan_model.pulse(2);
    ev('{gap: 1'b1, default: 1'b0});
    cyc(3);
    chk("eor", 12'h004, 12'(n_eor));
    cyc(15);
    fc(12'h020, 2'b10);
    // reverse read at load point hangs
    rst();
    fc(12'h021, 2'b10);
    unit.load_point <= 1'b1;
    i_tfc_chan_model.pulse(0);
    cyc(20);
    chk("rev", 12'h000, 12'(rev));
    chk("rasm", 12'h000, 12'(rasm));
    // write without write enable hangs
    rst();
    unit <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    i_tfc_chan_model.pulse(1);
    cyc(80);
    chk("gate", 12'h000, 12'(gate));
    chk("status", 12'h000, 12'(status[2]));
    close_out();
  end
endmodule
